// *** tms_cfg.svh ***
// constants for the temperature monitor sequencer
`ifndef TMS_CFG_SVH
`define TMS_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define TMS_CLK_HZ 50000000
`define TMS_MS_PER_S 1000
`define TMS_CYC_PER_MS (`TMS_CLK_HZ / `TMS_MS_PER_S)
`define TMS_T_LOCAL_MS 8'h0F
`define TMS_T_REMOTE_MS 8'h2C
`define TMS_T_REMOTE_RC_MS 8'h5D

// whole monitoring cycle lengths in ms
`define TMS_CYC_L_MS 8'h0F
`define TMS_CYC_R_MS 8'h2C
`define TMS_CYC_R_RC_MS 8'h5D
`define TMS_CYC_RL_MS 8'h3B
`define TMS_CYC_RL_RC_MS 8'h6C
`define TMS_CYC_RR_MS 8'h58
`define TMS_CYC_RR_RC_MS 8'hBA
`define TMS_CYC_RRL_MS 8'h67
`define TMS_CYC_RRL_RC_MS 8'hC9

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define TMS_REG_CONFIG 3'h0
`define TMS_REG_ADJUST 3'h1
`define TMS_REG_LOCAL 3'h2
`define TMS_REG_REM1 3'h3
`define TMS_REG_REM2 3'h4
`define TMS_REG_STATUS 3'h5

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TMS_CFG_W 4
`define TMS_CFG_RST 4'h7
`define TMS_ADJ_RST 8'h00
`define TMS_DATA_RST 12'h000
`define TMS_ST_BUSY 0
`define TMS_ST_SEL_LO 1
`define TMS_ST_PEND_LO 3

// ----------------------------------------------------------------
// sensors and correction arithmetic
// ----------------------------------------------------------------
`define TMS_S_LOCAL 2'h0
`define TMS_S_REM1 2'h1
`define TMS_S_REM2 2'h2
`define TMS_S_NONE 2'h3
`define TMS_KELVIN_OFS 24'sh000889
`define TMS_ETA_DEN 24'sh00012C
`define TMS_TEMP_MAX 24'sh0007FF
`define TMS_TEMP_MIN 24'shFFF800

`endif

// *** tms_diode_model.sv ***
// far-side model: sensing front end answering each conversion slot
`timescale 1ns/1ps

module tms_diode_model (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic conv_start, // slot start pulse
    input wire tms_pkg::tms_conv_req_t conv_req, // sensor and mode
    input wire logic [11:0] raw_local, // reading of the local sensor
    input wire logic [11:0] raw_rem1, // reading of remote one
    input wire logic [11:0] raw_rem2, // reading of remote two
    input wire logic slow, // answer late in the slot
    output logic conv_done, // result pulse
    output logic [11:0] conv_raw // result value
);
    import tms_pkg::*;
    int cnt;
    logic [1:0] sel;
    always_ff @(posedge ref_clk) begin
        conv_done <= 1'b0;
        if (rst) begin
            cnt <= 0;
            sel <= 2'h0;
            conv_raw <= 12'h000;
        end else if (conv_start) begin
            sel <= conv_req.sensor;
            cnt <= slow ? 120 : 3;
        end else if (cnt == 1) begin
            conv_done <= 1'b1;
            cnt <= 0;
            if (sel == 2'h0) begin
                conv_raw <= raw_local;
            end else if (sel == 2'h1) begin
                conv_raw <= raw_rem1;
            end else begin
                conv_raw <= raw_rem2;
            end
        end else begin
            if (cnt > 1) begin
                cnt <= cnt - 1;
            end
            // stale value must not look valid after the pulse
            if (conv_done) begin
                conv_raw <= ~conv_raw;
            end
        end
    end
endmodule

// *** tms_ideality_corr.sv ***
// ideality correction of a raw remote reading
`timescale 1ns/1ps
`include "tms_cfg.svh"

module tms_ideality_corr (
    input wire logic [11:0] raw, // reading taken at the trimmed ideality
    input wire logic [7:0] adj, // signed ideality adjustment
    input wire logic apply, // correct this reading
    output logic [11:0] corr // corrected reading
);
    logic signed [23:0] kel;
    logic signed [23:0] prod;
    logic signed [23:0] quo;
    logic signed [23:0] cel;
    logic [11:0] sat;

    // reading scales with 1/eta in kelvin: t * (300 - n) / 300
    always_comb begin
        kel = 24'(signed'(raw)) + `TMS_KELVIN_OFS;
        prod = kel * (`TMS_ETA_DEN - 24'(signed'(adj)));
        quo = prod / `TMS_ETA_DEN;
        cel = quo - `TMS_KELVIN_OFS;
        // keeps two's complement, 0.125 degree steps
        if (cel > `TMS_TEMP_MAX) begin
            sat = 12'h7FF;
        end else if (cel < `TMS_TEMP_MIN) begin
            sat = 12'h800;
        end else begin
            sat = cel[11:0];
        end
        corr = apply ? sat : raw;
    end

endmodule

// *** tms_monitor_seq.sv ***
// temperature monitor sequencer top: sequencing, registers, freeze
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "tms_cfg.svh"

// Operation
// - after reset the ideality adjustment is zero, meaning 1.008
// - adjustment is one signed two's complement byte, -128 to 127
// - remote ideality is 1.008 times 300 over 300 minus adjustment
// - cancellation bit clear skips series resistance cancellation
// - every result is presented as a 12-bit value
// - a finished conversion writes its sensor's data register
// - register being shifted out is frozen; pending result follows
// - local sensor alone: cycle lasts 15 ms
// - one remote alone: 44 ms, or 93 ms with cancellation
// - one remote plus local: 59 ms, or 108 ms with cancellation
// - both remotes, no local: 88 ms, or 186 ms with cancellation
// - all three sensors: 103 ms, or 201 ms with cancellation
// - each sensor has an enable; disabled sensors are skipped
// - each cycle end starts the next cycle automatically
// - results are two's complement in 0.125 degree steps
module tms_monitor_seq #(
    parameter int CYC_PER_MS = `TMS_CYC_PER_MS // cycles per ms
) (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [2:0] reg_addr, // register index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    input wire logic xfer_active, // shift register transfer running
    input wire logic [1:0] xfer_sel, // data register being shifted
    output logic conv_start, // start one sensor conversion
    output tms_pkg::tms_conv_req_t conv_req, // sensor and mode
    input wire logic conv_done, // raw result valid
    input wire logic [11:0] conv_raw // raw result at trimmed ideality
);
    import tms_pkg::*;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [1:0] next_sensor(input logic [2:0] en,
                                               input logic [1:0] from);
        logic [1:0] r;
        r = `TMS_S_NONE;
        for (int i = 2; i >= 0; i--) begin
            if (en[i] && (i >= int'(from))) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] slot_ms(input logic [1:0] s,
                                           input logic rc);
        logic [7:0] r;
        r = rc ? `TMS_T_REMOTE_RC_MS : `TMS_T_REMOTE_MS;
        if (s == `TMS_S_LOCAL) begin
            r = `TMS_T_LOCAL_MS;
        end
        return r;
    endfunction

    function automatic logic [7:0] cycle_ms(input logic [2:0] en,
                                            input logic rc);
        logic [7:0] r;
        case ({en[0], en[1] & en[2], en[1] ^ en[2], rc})
            4'h8, 4'h9: r = `TMS_CYC_L_MS;
            4'h2: r = `TMS_CYC_R_MS;
            4'h3: r = `TMS_CYC_R_RC_MS;
            4'hA: r = `TMS_CYC_RL_MS;
            4'hB: r = `TMS_CYC_RL_RC_MS;
            4'h4: r = `TMS_CYC_RR_MS;
            4'h5: r = `TMS_CYC_RR_RC_MS;
            4'hC: r = `TMS_CYC_RRL_MS;
            4'hD: r = `TMS_CYC_RRL_RC_MS;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    tms_cfg_t cfg_reg;
    tms_cfg_t cfg_next;
    logic [7:0] adj_reg;
    logic [7:0] adj_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    tms_state_t state_reg;
    tms_state_t state_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic [7:0] adj_snap_reg;
    logic [7:0] adj_snap_next;
    logic [11:0] raw_reg;
    logic [11:0] raw_next;
    logic start_reg;
    tms_conv_req_t req_reg;
    tms_conv_req_t req_next;
    logic [11:0] data_reg [3];
    logic [11:0] data_next [3];
    logic [11:0] pend_reg [3];
    logic [11:0] pend_next [3];
    logic [2:0] pvld_reg;
    logic [2:0] pvld_next;
    logic [2:0] en;
    logic [1:0] nxt_a;
    logic [1:0] nxt_b;
    logic tmr_start;
    logic tmr_done;
    logic cyc_wrap;
    logic slot_end;
    logic [11:0] raw_use;
    logic [11:0] result;

    assign en = {cfg_reg.rem2_en, cfg_reg.rem1_en, cfg_reg.local_en};

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_comb begin
        cfg_next = cfg_reg;
        adj_next = adj_reg;
        rdata_next = 16'h0000;
        if (reg_wr && (reg_addr == `TMS_REG_CONFIG)) begin
            cfg_next = reg_wdata[`TMS_CFG_W-1:0];
        end
        if (reg_wr && (reg_addr == `TMS_REG_ADJUST)) begin
            adj_next = reg_wdata[7:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                `TMS_REG_CONFIG: rdata_next = {12'h000, cfg_reg};
                `TMS_REG_ADJUST: rdata_next = {8'h00, adj_reg};
                `TMS_REG_LOCAL: rdata_next = {4'h0, data_reg[0]};
                `TMS_REG_REM1: rdata_next = {4'h0, data_reg[1]};
                `TMS_REG_REM2: rdata_next = {4'h0, data_reg[2]};
                `TMS_REG_STATUS: begin
                    rdata_next = {10'h000, pvld_reg, sel_reg,
                                  state_reg == ST_CONV};
                end
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_reg <= `TMS_CFG_RST;
            adj_reg <= `TMS_ADJ_RST;
            rdata_reg <= 16'h0000;
        end else begin
            cfg_reg <= cfg_next;
            adj_reg <= adj_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    tms_slot_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(tmr_start),
        .ms_len(slot_ms(sel_next, cfg_reg.rc)),
        .done(tmr_done)
    );

    assign slot_end = (state_reg == ST_CONV) && tmr_done;

    always_comb begin
        state_next = state_reg;
        sel_next = sel_reg;
        tmr_start = 1'b0;
        cyc_wrap = 1'b0;
        nxt_a = next_sensor(en, 2'(sel_reg + 2'h1));
        nxt_b = next_sensor(en, 2'h0);
        case (state_reg)
            ST_IDLE: begin
                if (nxt_b != `TMS_S_NONE) begin
                    state_next = ST_CONV;
                    sel_next = nxt_b;
                    tmr_start = 1'b1;
                end
            end
            ST_CONV: begin
                if (tmr_done && (nxt_a != `TMS_S_NONE)) begin
                    sel_next = nxt_a;
                    tmr_start = 1'b1;
                end else if (tmr_done) begin
                    cyc_wrap = 1'b1;
                    if (nxt_b != `TMS_S_NONE) begin
                        sel_next = nxt_b;
                        tmr_start = 1'b1;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // snapshot at slot start, so a new value waits for the next slot
        adj_snap_next = tmr_start ? adj_reg : adj_snap_reg;
        req_next = tmr_start ? tms_conv_req_t'({sel_next, cfg_reg.rc})
                             : req_reg;
        raw_next = conv_done ? conv_raw : raw_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            sel_reg <= `TMS_S_LOCAL;
            adj_snap_reg <= `TMS_ADJ_RST;
            req_reg <= '0;
            start_reg <= 1'b0;
            raw_reg <= `TMS_DATA_RST;
        end else begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            adj_snap_reg <= adj_snap_next;
            req_reg <= req_next;
            start_reg <= tmr_start;
            raw_reg <= raw_next;
        end
    end

    assign conv_start = start_reg;
    assign conv_req = req_reg;

    // ----------------------------------------------------------------
    // result correction and data registers
    // ----------------------------------------------------------------
    // a result arriving on the slot's last cycle is still taken
    assign raw_use = conv_done ? conv_raw : raw_reg;

    tms_ideality_corr u_corr (
        .raw(raw_use),
        .adj(adj_snap_reg),
        .apply(sel_reg != `TMS_S_LOCAL),
        .corr(result)
    );

    always_comb begin
        pvld_next = pvld_reg;
        for (int s = 0; s < 3; s++) begin
            data_next[s] = data_reg[s];
            pend_next[s] = pend_reg[s];
            if (slot_end && (sel_reg == 2'(s))) begin
                if (xfer_active && (xfer_sel == 2'(s))) begin
                    pend_next[s] = result;
                    pvld_next[s] = 1'b1;
                end else begin
                    data_next[s] = result;
                    pvld_next[s] = 1'b0;
                end
            end else if (pvld_reg[s] &&
                         !(xfer_active && (xfer_sel == 2'(s)))) begin
                data_next[s] = pend_reg[s];
                pvld_next[s] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pvld_reg <= 3'h0;
            for (int s = 0; s < 3; s++) begin
                data_reg[s] <= `TMS_DATA_RST;
                pend_reg[s] <= `TMS_DATA_RST;
            end
        end else begin
            pvld_reg <= pvld_next;
            for (int s = 0; s < 3; s++) begin
                data_reg[s] <= data_next[s];
                pend_reg[s] <= pend_next[s];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [31:0] cyc_cnt;
    logic cyc_ok;
    logic cfg_wr;
    logic [11:0] frz_view;
    logic [11:0] slot_data;

    assign cfg_wr = reg_wr && (reg_addr == `TMS_REG_CONFIG);
    assign frz_view = data_reg[xfer_sel];
    assign slot_data = data_reg[sel_reg];

    // cycle length only judged over a full cycle with steady config
    always_ff @(posedge ref_clk) begin
        if (rst || cyc_wrap) begin
            cyc_cnt <= 32'h00000000;
        end else begin
            cyc_cnt <= cyc_cnt + 32'h00000001;
        end
        if (rst || cfg_wr) begin
            cyc_ok <= 1'b0;
        end else if (cyc_wrap) begin
            cyc_ok <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_adj_reset_zero: assert property (
        $fell(rst) |-> (adj_reg == 8'h00) && (adj_snap_reg == 8'h00)
    ) else $error("adjustment not zero after reset");

    a_adj_byte_store: assert property (
        reg_wr && (reg_addr == `TMS_REG_ADJUST)
        |=> adj_reg == $past(reg_wdata[7:0])
    ) else $error("adjustment byte not stored");

    a_zero_adj_pass: assert property (
        (adj_snap_reg == 8'h00) |-> (result == raw_use)
    ) else $error("zero adjustment changed the reading");

    a_rc_slot_mode: assert property (
        conv_start && (conv_req.sensor != `TMS_S_LOCAL)
        |-> conv_req.rc == $past(cfg_reg.rc)
    ) else $error("cancellation mode not passed to conversion");

    a_rdata_width: assert property (
        $past(reg_rd) && ($past(reg_addr) >= `TMS_REG_LOCAL)
        && ($past(reg_addr) <= `TMS_REG_REM2) |-> reg_rdata[15:12] == 4'h0
    ) else $error("temperature read wider than 12 bits");

    a_result_write: assert property (
        slot_end && !xfer_active ##1 (sel_reg == $past(sel_reg))
        |-> slot_data == $past(result)
    ) else $error("result not written to its register");

    a_frozen_hold: assert property (
        xfer_active && $past(xfer_active) && $stable(xfer_sel)
        |-> $stable(frz_view)
    ) else $error("data register changed during transfer");

    a_pending_flush: assert property (
        (pvld_reg != 3'h0) && !xfer_active && !slot_end
        |=> pvld_reg == 3'h0
    ) else $error("pending result not flushed after transfer");

    a_cycle_len: assert property (
        cyc_wrap && cyc_ok && !cfg_wr
        |-> cyc_cnt + 32'h00000001 ==
            32'(cycle_ms(en, cfg_reg.rc)) * 32'(CYC_PER_MS)
    ) else $error("monitoring cycle length wrong");

    a_skip_disabled: assert property (
        tmr_start |-> en[sel_next]
    ) else $error("disabled sensor converted");

    a_auto_restart: assert property (
        cyc_wrap && (en != 3'h0) |-> tmr_start ##1 conv_start
    ) else $error("next cycle not started");

    a_local_raw: assert property (
        slot_end && (sel_reg == `TMS_S_LOCAL) |-> result == raw_use
    ) else $error("local reading was adjusted");

    c_full_cycle: cover property (cyc_wrap && cyc_ok);
    c_freeze_defer: cover property (slot_end && xfer_active
                                    && (xfer_sel == sel_reg));
    c_remote_rc: cover property (conv_start && conv_req.rc
                                 && (conv_req.sensor == `TMS_S_REM2));
    c_neg_adjust: cover property (slot_end && adj_snap_reg[7]);

endmodule

// *** tms_pkg.sv ***
// types shared by the temperature monitor sequencer
package tms_pkg;

    typedef enum logic {
        ST_IDLE,
        ST_CONV
    } tms_state_t;

    typedef struct packed {
        logic rc;
        logic rem2_en;
        logic rem1_en;
        logic local_en;
    } tms_cfg_t;

    typedef struct packed {
        logic [1:0] sensor;
        logic rc;
    } tms_conv_req_t;

endpackage

// *** tms_slot_timer.sv ***
// slot timer: counts a conversion slot given in milliseconds
`timescale 1ns/1ps

module tms_slot_timer #(
    parameter int CYC_PER_MS = 50000 // clock cycles per ms
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic start, // load and start a slot
    input wire logic [7:0] ms_len, // slot length in ms
    output logic done // last cycle of the slot
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic act_reg;
    logic act_next;
    logic [31:0] load;

    // restart on done keeps slots back to back with no lost cycle
    assign load = 32'(ms_len) * 32'(CYC_PER_MS) - 32'h00000001;
    assign done = act_reg && (cnt_reg == 32'h00000000);

    always_comb begin
        cnt_next = cnt_reg;
        act_next = act_reg;
        if (start) begin
            cnt_next = load;
            act_next = 1'b1;
        end else if (done) begin
            act_next = 1'b0;
        end else if (act_reg) begin
            cnt_next = cnt_reg - 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_reg <= 32'h00000000;
            act_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            act_reg <= act_next;
        end
    end

endmodule

// *** tms_tb.sv ***
// self-checking bench for the temperature monitor sequencer
`timescale 1ns/1ps
`include "tms_cfg.svh"

module tb;
    import tms_pkg::*;
    localparam int CPM = 10;
    logic ref_clk, rst, reg_wr, reg_rd, xfer_active, slow;
    logic conv_start, conv_done;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, got;
    logic [1:0] xfer_sel;
    tms_conv_req_t conv_req;
    logic [11:0] conv_raw, raw_l, raw_1, raw_2;
    int fail_count, checked, n;
    logic [3:0] cfgs [10] = '{4'h1, 4'h2, 4'h4, 4'hA, 4'h3, 4'hB, 4'h6,
                              4'hE, 4'h7, 4'hF};
    int msv [10] = '{15, 44, 44, 93, 59, 108, 88, 186, 103, 201};

    tms_monitor_seq #(.CYC_PER_MS(CPM)) dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .xfer_active(xfer_active),
        .xfer_sel(xfer_sel), .conv_start(conv_start),
        .conv_req(conv_req), .conv_done(conv_done), .conv_raw(conv_raw));

    tms_diode_model far (
        .ref_clk(ref_clk), .rst(rst), .conv_start(conv_start),
        .conv_req(conv_req), .raw_local(raw_l), .raw_rem1(raw_1),
        .raw_rem2(raw_2), .slow(slow), .conv_done(conv_done),
        .conv_raw(conv_raw));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, e, input string m);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask

    // bounded wait for the start of a slot of sensor s
    task automatic wait_start(input logic [1:0] s);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (!(conv_start === 1'b1 && conv_req.sensor === s)
                   && n < 4000);
        if (n >= 4000) begin
            fail_count++;
            $display("BAD t=%0t no conversion start", $time);
            report_and_stop();
        end
    endtask

    // signed truncating correction, saturated to the 12-bit range
    function automatic logic [11:0] corr(input logic [11:0] r,
                                         input logic [7:0] a);
        int t;
        t = ($signed(r) + `TMS_KELVIN_OFS) * (`TMS_ETA_DEN - $signed(a))
            / `TMS_ETA_DEN - `TMS_KELVIN_OFS;
        if (t > 2047) t = 2047;
        if (t < -2048) t = -2048;
        return t[11:0];
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] adj;
        logic [1:0] f;
        int st;
        rst = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        xfer_active = 1'b0;
        xfer_sel = 2'h0;
        slow = 1'b0;
        raw_l = 12'h0C8;
        raw_1 = 12'h190;
        raw_2 = 12'hF38;
        fail_count = 0;
        checked = 0;
        void'($urandom(88));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`TMS_REG_CONFIG);
        chk(got, 16'h0007, "config reset");
        rd(`TMS_REG_ADJUST);
        chk(got, 16'h0000, "adjust reset");
        wr(3'h6, 16'hFFFF);
        wr(`TMS_REG_LOCAL, 16'h0FFF);
        foreach (cfgs[i]) begin
            if (i >= 2 && i <= 7 && i != 5) begin
                rd(3'(i));
                chk(got, 16'h0000, "reset or refused");
            end
        end
        $display("test reset done");
        // each enable mix except local plus remote two: cycle length, slot count and mode
        foreach (cfgs[i]) begin
            slow <= 1'($urandom_range(1));
            wr(`TMS_REG_CONFIG, {12'h000, cfgs[i]});
            f = cfgs[i][0] ? 2'h0 : (cfgs[i][1] ? 2'h1 : 2'h2);
            wait_start(f);
            st = 0;
            n = 0;
            do begin
                @(posedge ref_clk);
                #1 n++;
                if (conv_start === 1'b1) begin
                    st++;
                    chk(16'(conv_req.rc), 16'(cfgs[i][3]), "rc");
                end
            end while (!(conv_start === 1'b1 && conv_req.sensor === f)
                       && n < 4000);
            chk(16'(n), 16'(msv[i] * CPM),
                "cycle");
            chk(16'(st), 16'($countones(cfgs[i][2:0])), "slots");
            if (n >= 4000) begin
                report_and_stop();
            end
        end
        $display("test cycle lengths done");
        wr(`TMS_REG_CONFIG, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            adj = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : (i == 2) ? 8'h00
                : 8'($urandom);
            raw_l <= 12'($urandom_range(1520) - 320);
            raw_1 <= 12'($urandom_range(1520) - 320);
            slow <= 1'($urandom_range(1));
            wr(`TMS_REG_ADJUST, {8'h00, adj});
            rd(`TMS_REG_ADJUST);
            chk(got, {8'h00, adj}, "adjust");
            wait_start(2'h1);
            wait_start(2'h1);
            rd(`TMS_REG_LOCAL);
            chk(got, {4'h0, raw_l}, "local");
            rd(`TMS_REG_REM1);
            chk(got, {4'h0, corr(raw_1, adj)}, "remote");
        end
        $display("test correction done");
        // freeze while shifting, and no freeze for another register
        wr(`TMS_REG_CONFIG, 16'h0002);
        wr(`TMS_REG_ADJUST, 16'h0000);
        raw_1 <= 12'h123;
        wait_start(2'h1);
        wait_start(2'h1);
        xfer_sel <= 2'h1;
        xfer_active <= 1'b1;
        raw_1 <= 12'h456;
        wait_start(2'h1);
        wait_start(2'h1);
        rd(`TMS_REG_REM1);
        chk(got, 16'h0123, "frozen");
        rd(`TMS_REG_STATUS);
        chk(got, 16'h0013, "pend flag");
        xfer_active <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(`TMS_REG_REM1);
        chk(got, 16'h0456, "pending");
        xfer_sel <= 2'h2;
        xfer_active <= 1'b1;
        raw_1 <= 12'h789;
        wait_start(2'h1);
        wait_start(2'h1);
        rd(`TMS_REG_REM1);
        chk(got, 16'h0789, "other sel");
        xfer_active <= 1'b0;
        $display("test freeze done");
        report_and_stop();
    end
endmodule
